// ### shared/shc_cfg.svh
// offsets, field positions, reset values and timing figures of the block
`ifndef SHC_CFG_SVH
`define SHC_CFG_SVH

// -----------------------------------------------------------------------
// register map
// -----------------------------------------------------------------------
`define SHC_OFS_START      7'h01
`define SHC_OFS_STATUS     7'h7C
`define SHC_OFS_MASK       7'h7D
`define SHC_REG_RST        8'h00
`define SHC_START_BIT      0
`define SHC_WAKE_BIT       4
`define SHC_STATUS_MASK    5'h1F

// -----------------------------------------------------------------------
// serial slave commands
// -----------------------------------------------------------------------
`define SHC_CMD_READ       8'h03
`define SHC_CMD_WRITE      8'h02

// -----------------------------------------------------------------------
// management frame
// -----------------------------------------------------------------------
`define SHC_PRE_ONES       6'h20
`define SHC_HDR_LAST       6'h0B
`define SHC_DATA_LAST      6'h0F
`define SHC_RD_END         6'h10
`define SHC_OP_READ        2'h2
`define SHC_OP_WRITE       2'h1
`define SHC_PHY_FIRST      5'h01
`define SHC_PHY_LAST       5'h04
`define SHC_REG_EXT_A      5'h1D
`define SHC_REG_EXT_B      5'h1F
`define SHC_REG_STD_LAST   5'h05

// -----------------------------------------------------------------------
// clock rates
// -----------------------------------------------------------------------
`define SHC_CORE_CLK_MHZ   125
`define SHC_SPI_MAX_MHZ    50
`define SHC_MDC_MAX_MHZ    25
`define SHC_MDC_MIN_CYC    (`SHC_CORE_CLK_MHZ / `SHC_MDC_MAX_MHZ)

`endif

// ### shared/shc_pkg.sv
// state types of the host configuration ports
package shc_pkg;

  // serial slave frame phase
  typedef enum logic [2:0] {
    SP_CMD  = 3'b001,
    SP_ADDR = 3'b010,
    SP_DATA = 3'b100
  } shc_spi_phase_e;

  // management frame state
  typedef enum logic [4:0] {
    MS_PRE  = 5'b00001,
    MS_SOF  = 5'b00010,
    MS_HDR  = 5'b00100,
    MS_TA   = 5'b01000,
    MS_DATA = 5'b10000
  } shc_mdio_state_e;

endpackage : shc_pkg

// ### verilog/shc_host_config_ports.sv
// host-side serial slave, management slave and event outputs of the switch
`timescale 1ns/1ps
`include "shc_cfg.svh"

module shc_host_config_ports
  import shc_pkg::*;
(
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // serial slave link
  input  wire logic       serial_clk,
  input  wire logic       serial_select_n,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_data_oe,
  input  wire logic       serial_data_sense,
  // management link
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  // switch events and control
  input  wire logic [3:0] intr_event,
  input  wire logic       wake_event,
  output logic            switch_enable,
  output logic            intr_out_n,
  output logic            wake_event_out_n
);

  // -----------------------------------------------------------------------
  // serial slave, link clock domain
  // -----------------------------------------------------------------------
  shc_spi_phase_e phase;
  logic [2:0]     bit_cnt;
  logic [6:0]     rx_sh;
  logic [6:0]     addr;
  logic           is_read;
  logic           is_write;
  logic [6:0]     rd_addr;
  logic [6:0]     wr_addr;
  logic [7:0]     wr_data;
  logic           rd_tgl;
  logic           wr_tgl;
  logic [6:0]     tx_sh;
  logic [7:0]     rd_data;
  logic           spi_mode;
  logic [7:0]     rx_byte;
  logic           byte_done;

  assign rx_byte   = {rx_sh, serial_data_in};
  assign byte_done = (bit_cnt == 3'h7);

  // bit capture on the rising edge; select high restarts the frame
  always_ff @(posedge serial_clk or posedge serial_select_n or posedge sys_rst)
  begin
    if (sys_rst || serial_select_n)
    begin
      bit_cnt <= 3'h0;
      rx_sh   <= 7'h00;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh   <= rx_byte[6:0];
    end
  end

  // frame phase, command decode and address counter
  always_ff @(posedge serial_clk or posedge serial_select_n or posedge sys_rst)
  begin
    if (sys_rst || serial_select_n)
    begin
      phase    <= SP_CMD;
      is_read  <= 1'b0;
      is_write <= 1'b0;
      addr     <= 7'h00;
    end
    else if (byte_done)
    begin
      case (phase)
        SP_CMD:
        begin
          phase    <= SP_ADDR;
          is_read  <= (rx_byte == `SHC_CMD_READ);
          is_write <= (rx_byte == `SHC_CMD_WRITE);
        end
        SP_ADDR:
        begin
          phase <= SP_DATA;
          addr  <= rx_byte[6:0];
        end
        default:
          addr <= addr + 7'h01;
      endcase
    end
  end

  // requests to the core: toggles survive select so no edge is lost
  always_ff @(posedge serial_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_tgl  <= 1'b0;
      wr_tgl  <= 1'b0;
      rd_addr <= 7'h00;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end
    else if (!serial_select_n && byte_done)
    begin
      if (phase == SP_ADDR && is_read)
      begin
        rd_addr <= rx_byte[6:0];
        rd_tgl  <= ~rd_tgl;
      end
      else if (phase == SP_DATA && is_read)
      begin
        rd_addr <= addr + 7'h01;
        rd_tgl  <= ~rd_tgl;
      end
      else if (phase == SP_DATA && is_write)
      begin
        wr_addr <= addr;
        wr_data <= rx_byte;
        wr_tgl  <= ~wr_tgl;
      end
    end
  end

  // read shifter; rd_data is settled half a serial period after request
  always_ff @(negedge serial_clk or posedge serial_select_n or posedge sys_rst)
  begin
    if (sys_rst || serial_select_n)
    begin
      serial_data_out <= 1'b0;
      tx_sh           <= 7'h00;
    end
    else if (phase == SP_DATA && is_read && bit_cnt == 3'h0)
    begin
      serial_data_out <= rd_data[7];
      tx_sh           <= rd_data[6:0];
    end
    else
    begin
      serial_data_out <= tx_sh[6];
      tx_sh           <= {tx_sh[5:0], 1'b0};
    end
  end

  // drive only while a read burst is in progress and strap picked serial mode
  assign serial_data_oe = spi_mode && !serial_select_n && is_read &&
                          (phase == SP_DATA);

  // -----------------------------------------------------------------------
  // synchronisers into the core domain
  // -----------------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic       strap_done;

  // bits: 0 read toggle, 1 write toggle, 2 mdc, 3 mdio, 4 strap
  // no reset: the strap level must already stand here when reset lets go
  always_ff @(posedge core_clk)
  begin
    sync1 <= {serial_data_sense, mdio_in, mdc, wr_tgl, rd_tgl};
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // strap caught once after reset release; pull-down means serial mode
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      strap_done <= 1'b0;
      spi_mode   <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      spi_mode   <= !sync2[4];
    end
  end

  logic rd_fire;
  logic wr_fire;
  logic mdc_rise;
  logic mdio_s;

  assign rd_fire  = (sync2[0] ^ sync3[0]) && spi_mode;
  assign wr_fire  = (sync2[1] ^ sync3[1]) && spi_mode;
  assign mdc_rise = sync2[2] && !sync3[2];
  assign mdio_s   = sync2[3];

  // -----------------------------------------------------------------------
  // register file and event status
  // -----------------------------------------------------------------------
  logic [7:0] regs [128];
  logic [4:0] stat;
  logic [4:0] next_stat;
  logic       rd_clear;

  // full 128-byte file; status is held apart and writes to it are dropped
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 128; i++)
        regs[i] <= `SHC_REG_RST;
    end
    else if (wr_fire && wr_addr != `SHC_OFS_STATUS)
      regs[wr_addr] <= wr_data;
  end

  // read answer, taken by the link side at the next falling edge
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rd_data <= 8'h00;
    else if (rd_fire)
      rd_data <= (rd_addr == `SHC_OFS_STATUS) ? {3'h0, stat}
                                              : regs[rd_addr];
  end

  // sticky status: a new event beats a read clear in the same cycle
  assign rd_clear  = rd_fire && (rd_addr == `SHC_OFS_STATUS);
  assign next_stat = (stat & ~(rd_clear ? `SHC_STATUS_MASK : 5'h00)) |
                     {wake_event, intr_event};

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      stat <= 5'h00;
    else
      stat <= next_stat;
  end

  // start bit and event outputs
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      switch_enable    <= 1'b0;
      intr_out_n       <= 1'b1;
      wake_event_out_n <= 1'b1;
    end
    else
    begin
      switch_enable    <= regs[`SHC_OFS_START][`SHC_START_BIT];
      intr_out_n       <= !(|(stat[3:0] &
                              regs[`SHC_OFS_MASK][3:0]));
      wake_event_out_n <= !(stat[4] &&
                            regs[`SHC_OFS_MASK][`SHC_WAKE_BIT]);
    end
  end

  // -----------------------------------------------------------------------
  // management slave, oversampled mdc
  // -----------------------------------------------------------------------
  shc_mdio_state_e mstate;
  logic [5:0]      mcnt;
  logic [15:0]     msh;
  logic            mread;
  logic            mhit;
  logic [1:0]      mport;
  logic [2:0]      mslot;
  logic [15:0]     phy_regs [4][8];
  logic [11:0]     hdr;
  logic [4:0]      hdr_reg;
  logic [4:0]      hdr_phy;
  logic            slot_ok;
  logic [2:0]      slot;
  logic            m_store;

  assign hdr     = {msh[10:0], mdio_s};
  assign hdr_phy = hdr[9:5];
  assign hdr_reg = hdr[4:0];

  // only the standard set plus two extended registers exist per port
  always_comb
  begin
    slot_ok = 1'b1;
    slot    = hdr_reg[2:0];
    if (hdr_reg == `SHC_REG_EXT_A)
      slot = 3'h6;
    else if (hdr_reg == `SHC_REG_EXT_B)
      slot = 3'h7;
    else if (hdr_reg > `SHC_REG_STD_LAST)
      slot_ok = 1'b0;
  end

  // frame sequencer; any glitch in preamble or opcode drops to hunting
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mstate   <= MS_PRE;
      mcnt     <= 6'h00;
      msh      <= 16'h0000;
      mread    <= 1'b0;
      mhit     <= 1'b0;
      mport    <= 2'h0;
      mslot    <= 3'h0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end
    else if (mdc_rise)
    begin
      case (mstate)
        MS_PRE:
          if (mdio_s)
            mcnt <= (mcnt == `SHC_PRE_ONES) ? mcnt : mcnt + 6'h01;
          else if (mcnt == `SHC_PRE_ONES)
            mstate <= MS_SOF;
          else
            mcnt <= 6'h00;
        MS_SOF:
        begin
          mcnt   <= 6'h00;
          mstate <= mdio_s ? MS_HDR : MS_PRE;
        end
        MS_HDR:
        begin
          msh  <= {msh[14:0], mdio_s};
          mcnt <= mcnt + 6'h01;
          if (mcnt == `SHC_HDR_LAST)
          begin
            mcnt   <= 6'h00;
            mread  <= (hdr[11:10] == `SHC_OP_READ);
            mhit   <= slot_ok && hdr_phy >= `SHC_PHY_FIRST &&
                      hdr_phy <= `SHC_PHY_LAST;
            mport  <= 2'(hdr_phy - `SHC_PHY_FIRST);
            mslot  <= slot;
            mstate <= (hdr[11:10] == `SHC_OP_READ ||
                       hdr[11:10] == `SHC_OP_WRITE) ? MS_TA : MS_PRE;
          end
        end
        MS_TA:
          if (mread)
          begin
            mdio_oe <= mhit;
            mdio_out <= 1'b0;
            msh     <= phy_regs[mport][mslot];
            mstate  <= MS_DATA;
          end
          else if (mcnt == 6'h01)
          begin
            mcnt   <= 6'h00;
            mstate <= MS_DATA;
          end
          else
            mcnt <= 6'h01;
        default:
        begin
          mcnt <= mcnt + 6'h01;
          msh  <= {msh[14:0], mdio_s};
          if (mread)
            mdio_out <= msh[15];
          if ((mread && mcnt == `SHC_RD_END) ||
              (!mread && mcnt == `SHC_DATA_LAST))
          begin
            mdio_oe <= 1'b0;
            mcnt    <= 6'h00;
            mstate  <= MS_PRE;
          end
        end
      endcase
    end
  end

  assign m_store = mdc_rise && mstate == MS_DATA && !mread && mhit &&
                   mcnt == `SHC_DATA_LAST;

  // per-port PHY register storage
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int p = 0; p < 4; p++)
        for (int r = 0; r < 8; r++)
          phy_regs[p][r] <= 16'h0000;
    end
    else if (m_store)
      phy_regs[mport][mslot] <= {msh[14:0], mdio_s};
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_START_BIT: assert property (
    (wr_fire && wr_addr == `SHC_OFS_START && wr_data[0]) |-> ##2 switch_enable)
    else $error("start bit write did not enable the switch");

  AST_INTR_ASSERT: assert property (
    (intr_event[0] && regs[`SHC_OFS_MASK][0] && !wr_fire) |-> ##2 !intr_out_n)
    else $error("masked interrupt event did not assert the output");

  AST_INTR_MASKED: assert property (
    (regs[`SHC_OFS_MASK][3:0] == 4'h0)[*2] |=> intr_out_n)
    else $error("interrupt asserted with every mask bit off");

  AST_WAKE_ASSERT: assert property (
    (stat[4] && regs[`SHC_OFS_MASK][4]) |=> !wake_event_out_n)
    else $error("wake output not asserted for masked wake status");

  AST_STATUS_SET: assert property (
    (intr_event != 4'h0) |=> ((stat[3:0] & $past(intr_event)) ==
                              $past(intr_event)))
    else $error("interrupt event lost in status");

  AST_STATUS_CLEAR: assert property (
    (rd_clear && intr_event == 4'h0 && !wake_event) |=> stat == 5'h00)
    else $error("status read did not clear the status");

  AST_WRITE_STORE: assert property (
    (wr_fire && wr_addr != `SHC_OFS_STATUS) |=>
      regs[$past(wr_addr)] == $past(wr_data))
    else $error("serial write not stored");

  AST_PREAMBLE: assert property (
    $rose(mstate == MS_SOF) |-> $past(mcnt) == `SHC_PRE_ONES)
    else $error("frame accepted without full preamble");

  AST_MDIO_HIT: assert property (
    mdio_oe |-> (mhit && mread && mstate == MS_DATA))
    else $error("management output driven outside a valid read");

  AST_ADDR_WRAP: assert property (
    @(posedge serial_clk) disable iff (sys_rst || serial_select_n)
    (phase == SP_DATA && byte_done && addr == 7'h7F) |=> addr == 7'h00)
    else $error("address counter did not wrap to zero");

endmodule : shc_host_config_ports

// ### bench/shc_host_model.sv
// external master model for the serial slave and management links
`timescale 1ns/1ps
`include "shc_cfg.svh"

module shc_host_model
(
  // serial slave link
  output logic      serial_clk,
  output logic      serial_select_n,
  output logic      serial_data_in,
  input  wire logic serial_pin,
  // management link
  output logic      mdc,
  output logic      mdio_drv_oe,
  output logic      mdio_drv,
  input  wire logic mdio_pin
);
  // ---------------------------------------------------------------
  // transfer buffers and link timing
  // ---------------------------------------------------------------
  logic [7:0]    d [4];
  logic [16:0]   md;
  localparam time HALF = 80;

  // link clocks stand still low outside frames
  initial
  begin
    serial_clk      = 1'b0;
    serial_select_n = 1'b1;
    serial_data_in  = 1'b0;
    mdc             = 1'b0;
    mdio_drv_oe     = 1'b0;
    mdio_drv        = 1'b0;
    md              = '0;
  end

  // one byte, msb first; data out sampled on the rising edge
  task automatic sbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      serial_data_in = b[i];
      #HALF serial_clk = 1'b1;
      r[i] = serial_pin;
      #HALF serial_clk = 1'b0;
    end
  endtask : sbyte

  // command, address, then n data bytes from or into d
  task automatic spi_burst(input logic [7:0] cmd, input logic [6:0] a,
                           input int n);
    logic [7:0] r;
    serial_select_n = 1'b0;
    #HALF;
    sbyte(cmd, r);
    sbyte({1'b0, a}, r);
    for (int k = 0; k < n; k++)
      sbyte(d[k], d[k]);
    #HALF serial_select_n = 1'b1;
    // no stale level left on the idle input
    serial_data_in = ~serial_data_in;
    #(5 * HALF);
  endtask : spi_burst

  // one management bit; line level shifted into md at rising edge
  task automatic mbit(input logic oe, input logic b);
    mdio_drv_oe = oe;
    mdio_drv    = b;
    #HALF mdc = 1'b1;
    md = {md[15:0], mdio_pin};
    #HALF mdc = 1'b0;
  endtask : mbit

  // whole frame; a read releases the line from the turnaround on
  task automatic mdio_frame(input int pre, input logic [1:0] op,
                            input logic [4:0] phy, input logic [4:0] rg,
                            input logic [15:0] wd);
    logic [31:0] w;
    w = {2'b01, op, phy, rg, 2'b10, wd};
    for (int i = 0; i < pre; i++)
      mbit(1'b1, 1'b1);
    for (int i = 31; i >= 0; i--)
      mbit(op == `SHC_OP_WRITE || i > 17, w[i]);
    mdio_drv_oe = 1'b0;
    #(4 * HALF);
  endtask : mdio_frame
endmodule : shc_host_model

// ### bench/testbench.sv
// self-checking bench for the host configuration ports
`timescale 1ns/1ps
`include "shc_cfg.svh"

module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic       core_clk;
  logic       sys_rst;
  logic [3:0] intr_event;
  logic       wake_event;
  logic       strap_hi;
  wire        serial_clk, serial_select_n, serial_data_in;
  wire        serial_data_out, serial_data_oe, spi_pin;
  wire        mdc, mdio_out, mdio_oe, m_oe, m_drv, mdio_pin;
  wire        switch_enable, intr_out_n, wake_event_out_n;
  int         fails;
  int         tests_run;
  int         cyc;

  // pull resistor on the data-out pin doubles as the mode strap
  assign spi_pin  = serial_data_oe ? serial_data_out : strap_hi;
  // management line has a pull-up when nobody drives it
  assign mdio_pin = mdio_oe ? mdio_out : (m_oe ? m_drv : 1'b1);

  // ---------------------------------------------------------------
  // design and far-side master
  // ---------------------------------------------------------------
  shc_host_config_ports dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .serial_data_sense(spi_pin), .mdc(mdc), .mdio_in(mdio_pin),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .intr_event(intr_event),
    .wake_event(wake_event), .switch_enable(switch_enable),
    .intr_out_n(intr_out_n), .wake_event_out_n(wake_event_out_n));

  shc_host_model u_host (
    .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_data_in(serial_data_in), .serial_pin(spi_pin), .mdc(mdc),
    .mdio_drv_oe(m_oe), .mdio_drv(m_drv), .mdio_pin(mdio_pin));

  // core clock, 8 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // compare, access and reporting tasks
  // ---------------------------------------------------------------
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t level %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic chkv(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chkv

  task automatic wr(input logic [7:0] cmd, input logic [6:0] a,
                    input logic [23:0] v, input int n);
    for (int k = 0; k < 3; k++)
      u_host.d[k] = v[23 - 8 * k -: 8];
    u_host.spi_burst(cmd, a, n);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [23:0] e,
                    input int n);
    u_host.spi_burst(`SHC_CMD_READ, a, n);
    for (int k = 0; k < n; k++)
      chkv({9'h000, u_host.d[k]}, {9'h000, e[23 - 8 * k -: 8]});
  endtask : rd

  // one-cycle event, then let the flags settle
  task automatic pulse(input logic [3:0] ev, input logic wk);
    @(posedge core_clk) #1;
    intr_event = ev;
    wake_event = wk;
    @(posedge core_clk) #1;
    intr_event = 4'h0;
    wake_event = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
  endtask : pulse

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // hang guard, about twice the expected run
  initial
    cyc = 0;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      $display("MISMATCH t=%0t run timed out", $time);
      results();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst    = 1'b1;
    intr_event = 4'h0;
    wake_event = 1'b0;
    strap_hi   = 1'b0;
    fails      = 0;
    tests_run  = 0;
    repeat (20) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk1(switch_enable, 1'b0);
    chk1(intr_out_n, 1'b1);
    chk1(wake_event_out_n, 1'b1);
    rd(`SHC_OFS_STATUS, 24'h000000, 2);
    rd(`SHC_OFS_START, 24'h000000, 1);
    // burst across the top of the map and back to zero
    wr(`SHC_CMD_WRITE, 7'h7E, 24'hA55AC3, 3);
    rd(7'h7E, 24'hA55AC3, 3);
    // unknown command must leave storage alone
    wr(8'h05, 7'h7E, 24'h110000, 1);
    rd(7'h7E, 24'hA50000, 1);
    // status ignores writes; mask sits right behind it
    wr(`SHC_CMD_WRITE, `SHC_OFS_STATUS, 24'hFF1100, 2);
    rd(`SHC_OFS_STATUS, 24'h001100, 2);
    wr(`SHC_CMD_WRITE, `SHC_OFS_START, 24'h010000, 1);
    chk1(switch_enable, 1'b1);
    // only bit 0 of the interrupt conditions is unmasked
    for (int i = 3; i >= 0; i--)
    begin
      pulse(4'h1 << i, 1'b0);
      chk1(intr_out_n, i != 0);
    end
    chk1(wake_event_out_n, 1'b1);
    pulse(4'h0, 1'b1);
    chk1(wake_event_out_n, 1'b0);
    rd(`SHC_OFS_STATUS, 24'h1F0000, 1);
    chk1(intr_out_n, 1'b1);
    chk1(wake_event_out_n, 1'b1);
    rd(`SHC_OFS_STATUS, 24'h000000, 1);
    // wake masked: recorded but not signalled
    wr(`SHC_CMD_WRITE, `SHC_OFS_MASK, 24'h010000, 1);
    pulse(4'h0, 1'b1);
    chk1(wake_event_out_n, 1'b1);
    rd(`SHC_OFS_STATUS, 24'h100000, 1);
    // management frames
    u_host.mdio_frame(32, `SHC_OP_WRITE, 5'h02, 5'h01, 16'hBEEF);
    u_host.mdio_frame(32, `SHC_OP_READ, 5'h02, 5'h01, 16'h0000);
    chkv(u_host.md, 17'h0BEEF);
    u_host.mdio_frame(16, `SHC_OP_WRITE, 5'h02, 5'h01, 16'h1234);
    u_host.mdio_frame(32, `SHC_OP_READ, 5'h02, 5'h01, 16'h0000);
    chkv(u_host.md, 17'h0BEEF);
    u_host.mdio_frame(32, `SHC_OP_WRITE, 5'h04, 5'h1F, 16'h5A5A);
    u_host.mdio_frame(32, `SHC_OP_READ, 5'h04, 5'h1F, 16'h0000);
    chkv(u_host.md, 17'h05A5A);
    u_host.mdio_frame(32, `SHC_OP_READ, 5'h05, 5'h01, 16'h0000);
    chkv(u_host.md, 17'h1FFFF);
    // strap pulled high over a mid-run reset: the serial port stays off
    strap_hi = 1'b1;
    @(posedge core_clk) #1 sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk1(switch_enable, 1'b0);
    wr(`SHC_CMD_WRITE, `SHC_OFS_START, 24'h010000, 1);
    chk1(switch_enable, 1'b0);
    rd(`SHC_OFS_START, 24'hFF0000, 1);
    results();
  end
endmodule : testbench
